// [design/ssta_alu.sv]
// shift, borrow subtract, zero-extend and table access datapath
//
// Behaviour
// - register-count left shift, one cycle, N Z
// - literal-count left shift, one cycle, N Z
// - memory minus working register minus borrow, all flags
// - register minus ten-bit literal minus borrow, writeback
// - working register minus memory minus borrow, flags
// - five-bit literal minus base minus borrow, one cycle
// - table read high byte, two cycles, no flags
// - table read low word, two cycles, no flags
// - table write high byte, two cycles, no flags
// - table write low word, two cycles, no flags
// - zero-extend, one cycle, updates C Z N
`include "ssta_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ssta_alu
   import ssta_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // instruction issue
   input wire logic req_valid_in,
   input wire ssta_req_t req_in,
   input wire ssta_flags_t flags_in,
   output logic busy_out,
   // program memory port, read data is sampled in the same cycle the read request is driven
   output logic prog_req_valid_out,
   output ssta_prog_req_t prog_req_out,
   input wire logic [23:0] prog_rdata_in,
   // result
   output logic result_valid_out,
   output logic result_write_out,
   output logic [15:0] result_out,
   output logic flags_write_out,
   output ssta_flags_t flags_out
);
   // -----------------------------------------------------------------
   // sequencing
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {SSTA_IDLE, SSTA_TABLE} ssta_state_t;
   ssta_state_t state_q, state_d;
   ssta_op_t tbl_op_q;

   wire logic issue_w = req_valid_in & (state_q == SSTA_IDLE);
   wire logic op_tbl_rd_h = req_in.op == SSTA_OP_TBL_RD_HIGH;
   wire logic op_tbl_rd_l = req_in.op == SSTA_OP_TBL_RD_LOW;
   wire logic op_tbl_wr_h = req_in.op == SSTA_OP_TBL_WR_HIGH;
   wire logic op_tbl_wr_l = req_in.op == SSTA_OP_TBL_WR_LOW;
   wire logic op_table_w = op_tbl_rd_h | op_tbl_rd_l | op_tbl_wr_h | op_tbl_wr_l;
   wire logic tbl_start_w = issue_w & op_table_w;

   always_comb begin
      state_d = state_q;
      case (state_q)
         SSTA_IDLE: begin
            if (tbl_start_w) begin
               state_d = SSTA_TABLE;
            end
         end
         SSTA_TABLE: begin
            // second cycle of the two-cycle table access
            state_d = SSTA_IDLE;
         end
         default: begin
            state_d = SSTA_IDLE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // single-cycle arithmetic
   // -----------------------------------------------------------------
   // only the low four count bits matter for a 16-bit operand
   wire logic [3:0] shamt_reg_w = req_in.opb[3:0] & 4'(`SSTA_SHIFT_MASK);
   wire logic [3:0] shamt_lit_w = req_in.lit[3:0] & 4'(`SSTA_SHIFT_MASK);
   wire logic [15:0] shl_reg_w = req_in.opa << shamt_reg_w;
   wire logic [15:0] shl_lit_w = req_in.opa << shamt_lit_w;
   wire logic [15:0] lit5_w = req_in.lit & `SSTA_LIT5_MASK;
   wire logic [15:0] lit10_w = req_in.lit & `SSTA_LIT10_MASK;
   wire logic [15:0] zext_w = {8'h00, req_in.opa[7:0]};

   // opa is memory operand or named/base register, opb the working register
   logic [15:0] sub_min_w, sub_sub_w;
   always_comb begin
      sub_min_w = req_in.opa;
      sub_sub_w = req_in.opb;
      case (req_in.op)
         SSTA_OP_SUBTRACT_WITH_BORROW_OP_MEM: begin
            sub_min_w = req_in.opa;
            sub_sub_w = req_in.opb;
         end
         SSTA_OP_SUBTRACT_WITH_BORROW_OP_LIT10: begin
            sub_min_w = req_in.opa;
            sub_sub_w = lit10_w;
         end
         SSTA_OP_REVERSE_SUBTRACT_BORROW_OP_MEM: begin
            sub_min_w = req_in.opb;
            sub_sub_w = req_in.opa;
         end
         SSTA_OP_REVERSE_SUBTRACT_BORROW_OP_LIT5: begin
            sub_min_w = lit5_w;
            sub_sub_w = req_in.opa;
         end
         default: begin
            sub_min_w = req_in.opa;
            sub_sub_w = req_in.opb;
         end
      endcase
   end

   wire logic [15:0] sub_diff_w;
   ssta_flags_t sub_flags_w;
   ssta_subber u_subber (
      .minuend_in(sub_min_w),
      .subtrahend_in(sub_sub_w),
      .carry_in(flags_in.c),
      .diff_out(sub_diff_w),
      .flags_out(sub_flags_w)
   );

   wire logic is_sub_w = (req_in.op == SSTA_OP_SUBTRACT_WITH_BORROW_OP_MEM) | (req_in.op == SSTA_OP_SUBTRACT_WITH_BORROW_OP_LIT10) |
      (req_in.op == SSTA_OP_REVERSE_SUBTRACT_BORROW_OP_MEM) | (req_in.op == SSTA_OP_REVERSE_SUBTRACT_BORROW_OP_LIT5);
   wire logic is_shl_w = (req_in.op == SSTA_OP_SHIFT_LEFT_REG) |
      (req_in.op == SSTA_OP_SHIFT_LEFT_LIT);
   wire logic is_zext_w = req_in.op == SSTA_OP_ZERO_EXTEND;
   wire logic one_cycle_w = issue_w & (is_sub_w | is_shl_w | is_zext_w);

   wire logic [15:0] shl_res_w = (req_in.op == SSTA_OP_SHIFT_LEFT_REG) ? shl_reg_w : shl_lit_w;
   wire logic [15:0] alu_res_w = is_sub_w ? sub_diff_w : (is_shl_w ? shl_res_w : zext_w);

   // shifts touch only n and z, carry and overflow pass through
   ssta_flags_t shl_flags_w;
   assign shl_flags_w.c = flags_in.c;
   assign shl_flags_w.ov = flags_in.ov;
   assign shl_flags_w.dc = flags_in.dc;
   assign shl_flags_w.n = shl_res_w[15];
   assign shl_flags_w.z = shl_res_w == 16'h0000;

   // carry of zero-extend is set, like a nonnegative result; n always clear
   ssta_flags_t zext_flags_w;
   assign zext_flags_w.c = 1'b1;
   assign zext_flags_w.ov = flags_in.ov;
   assign zext_flags_w.dc = flags_in.dc;
   assign zext_flags_w.n = 1'b0;
   assign zext_flags_w.z = zext_w == 16'h0000;

   wire ssta_flags_t alu_flags_w = is_sub_w ? sub_flags_w : (is_shl_w ? shl_flags_w : zext_flags_w);

   // -----------------------------------------------------------------
   // table access
   // -----------------------------------------------------------------
   ssta_prog_req_t prog_req_d;
   assign prog_req_d.write = op_tbl_wr_h | op_tbl_wr_l;
   assign prog_req_d.high = op_tbl_rd_h | op_tbl_wr_h;
   assign prog_req_d.addr = req_in.paddr;
   // high write carries only the low byte of the source
   assign prog_req_d.wdata = op_tbl_wr_h ? {8'h00, req_in.opa[7:0]} : req_in.opa;

   wire logic tbl_rd_done_w = (state_q == SSTA_TABLE) &
      ((tbl_op_q == SSTA_OP_TBL_RD_HIGH) | (tbl_op_q == SSTA_OP_TBL_RD_LOW));
   wire logic [15:0] tbl_rd_w = (tbl_op_q == SSTA_OP_TBL_RD_HIGH) ?
      {8'h00, prog_rdata_in[23:16]} : prog_rdata_in[15:0];

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= SSTA_IDLE;
         tbl_op_q <= SSTA_OP_NONE;
         busy_out <= 1'b0;
         prog_req_valid_out <= 1'b0;
         prog_req_out <= '0;
         result_valid_out <= 1'b0;
         result_write_out <= 1'b0;
         result_out <= `SSTA_DATA_RST;
         flags_write_out <= 1'b0;
         flags_out <= `SSTA_FLAGS_RST;
      end else begin
         state_q <= state_d;
         busy_out <= tbl_start_w;
         prog_req_valid_out <= tbl_start_w;
         if (tbl_start_w) begin
            tbl_op_q <= req_in.op;
            prog_req_out <= prog_req_d;
         end
         // table ops retire in the second cycle, flags untouched
         result_valid_out <= one_cycle_w | (state_q == SSTA_TABLE);
         result_write_out <= one_cycle_w | tbl_rd_done_w;
         flags_write_out <= one_cycle_w;
         if (one_cycle_w) begin
            result_out <= alu_res_w;
            flags_out <= alu_flags_w;
         end else if (tbl_rd_done_w) begin
            result_out <= tbl_rd_w;
         end
      end
   end
endmodule // ssta_alu
`default_nettype wire

// [include/ssta_consts.svh]
// constants for the shift, subtract-with-borrow and table access datapath
`ifndef SSTA_CONSTS_SVH
`define SSTA_CONSTS_SVH
`define SSTA_DATA_W 16
`define SSTA_PROG_W 24
`define SSTA_PADDR_W 24
`define SSTA_FLAG_C 0
`define SSTA_FLAG_Z 1
`define SSTA_FLAG_OV 2
`define SSTA_FLAG_N 3
`define SSTA_FLAG_DC 4
`define SSTA_FLAGS_RST 5'h00
`define SSTA_DATA_RST 16'h0000
`define SSTA_SINGLE_CYCLES 1
`define SSTA_TABLE_CYCLES 2
`define SSTA_LIT5_MASK 16'h001F
`define SSTA_LIT10_MASK 16'h03FF
`define SSTA_SHIFT_MASK 16'h000F
`endif

// [include/ssta_pkg.sv]
// types shared by the datapath files
package ssta_pkg;
   typedef enum logic [3:0] {
      SSTA_OP_NONE,
      SSTA_OP_SHIFT_LEFT_REG,
      SSTA_OP_SHIFT_LEFT_LIT,
      SSTA_OP_SUBTRACT_WITH_BORROW_OP_MEM,
      SSTA_OP_SUBTRACT_WITH_BORROW_OP_LIT10,
      SSTA_OP_REVERSE_SUBTRACT_BORROW_OP_MEM,
      SSTA_OP_REVERSE_SUBTRACT_BORROW_OP_LIT5,
      SSTA_OP_TBL_RD_HIGH,
      SSTA_OP_TBL_RD_LOW,
      SSTA_OP_TBL_WR_HIGH,
      SSTA_OP_TBL_WR_LOW,
      SSTA_OP_ZERO_EXTEND
   } ssta_op_t;

   // c, z, ov, n, dc from bit 0 upward
   typedef struct packed {
      logic dc;
      logic n;
      logic ov;
      logic z;
      logic c;
   } ssta_flags_t;

   typedef struct packed {
      ssta_op_t op;
      logic [15:0] opa;
      logic [15:0] opb;
      logic [15:0] lit;
      logic [23:0] paddr;
   } ssta_req_t;

   typedef struct packed {
      logic write;
      logic high;
      logic [23:0] addr;
      logic [15:0] wdata;
   } ssta_prog_req_t;
endpackage

// [design/ssta_subber.sv]
// borrow subtractor with flag generation
`timescale 1ns/1ns
`default_nettype none
module ssta_subber
   import ssta_pkg::*;
(
   // operands
   input wire logic [15:0] minuend_in,
   input wire logic [15:0] subtrahend_in,
   input wire logic carry_in,
   // result
   output logic [15:0] diff_out,
   output ssta_flags_t flags_out
);
   wire logic borrow_in = ~carry_in;
   wire logic [16:0] full_w = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {16'h0000, borrow_in};
   wire logic [4:0] nib_w = {1'b0, minuend_in[3:0]} - {1'b0, subtrahend_in[3:0]} - {4'h0, borrow_in};
   assign diff_out = full_w[15:0];
   // carry reads as not-borrow on subtraction
   assign flags_out.c = ~full_w[16];
   assign flags_out.dc = ~nib_w[4];
   assign flags_out.n = full_w[15];
   assign flags_out.z = (full_w[15:0] == 16'h0000);
   assign flags_out.ov = (minuend_in[15] ^ subtrahend_in[15]) & (minuend_in[15] ^ full_w[15]);
endmodule // ssta_subber
`default_nettype wire

// [tb/ssta_alu_monitor.sv]
// port assertions for the datapath
`timescale 1ns/1ns
`default_nettype none
module ssta_alu_monitor
   import ssta_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic req_valid_in,
   input wire ssta_req_t req_in,
   input wire ssta_flags_t flags_in,
   input wire logic busy_out,
   input wire logic prog_req_valid_out,
   input wire ssta_prog_req_t prog_req_out,
   input wire logic result_valid_out,
   input wire logic result_write_out,
   input wire logic [15:0] result_out,
   input wire logic flags_write_out,
   input wire ssta_flags_t flags_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   wire logic take = req_valid_in && !busy_out;
   wire logic tbl = take && req_in.op >= SSTA_OP_TBL_RD_HIGH && req_in.op <= SSTA_OP_TBL_WR_LOW;
   wire logic wr = tbl && req_in.op >= SSTA_OP_TBL_WR_HIGH;
   wire logic one = take && req_in.op != SSTA_OP_NONE && !tbl;
   wire logic sh = one && req_in.op <= SSTA_OP_SHIFT_LEFT_LIT;
   wire logic sb = take && req_in.op >= SSTA_OP_SUBTRACT_WITH_BORROW_OP_MEM && req_in.op <= SSTA_OP_REVERSE_SUBTRACT_BORROW_OP_LIT5;
   wire logic ze = take && req_in.op == SSTA_OP_ZERO_EXTEND;
   table_busy_a: assert property (tbl |=> busy_out && prog_req_valid_out && !result_valid_out)
      else $error("table op did not hold busy for its first cycle");
   table_done_a: assert property (tbl |-> ##2 result_valid_out && !flags_write_out)
      else $error("table op did not retire in two cycles without flags");
   prog_write_a: assert property (wr |=> prog_req_out.write
      && prog_req_out.addr == $past(req_in.paddr)
      && prog_req_out.wdata[7:0] == $past(req_in.opa[7:0]))
      else $error("program write request wrong");
   prog_read_a: assert property ((tbl && !wr) |=> prog_req_valid_out
      && !prog_req_out.write && prog_req_out.addr == $past(req_in.paddr)
      && prog_req_out.high == ($past(req_in.op) == SSTA_OP_TBL_RD_HIGH))
      else $error("program read request wrong");
   prog_low_a: assert property ((wr && req_in.op == SSTA_OP_TBL_WR_LOW) |=>
      !prog_req_out.high && prog_req_out.wdata == $past(req_in.opa))
      else $error("low program write data wrong");
   no_wback_a: assert property (wr |-> ##2 !result_write_out)
      else $error("table write wrote a register");
   single_cyc_a: assert property (one |=> result_valid_out && result_write_out && flags_write_out)
      else $error("single cycle op did not retire next cycle");
   shift_keep_a: assert property (sh |=> flags_out.c == $past(flags_in.c)
      && flags_out.ov == $past(flags_in.ov) && flags_out.dc == $past(flags_in.dc))
      else $error("shift changed carry, overflow or digit carry");
   zext_high_a: assert property (ze |=> result_out[15:8] == 8'h00 && !flags_out.n)
      else $error("zero extend left high byte or negative set");
   zero_flag_a: assert property ((sh || ze) |=> flags_out.z == (result_out == 16'h0000))
      else $error("zero flag does not match result");
   sub_neg_a: assert property (sb |=> flags_out.n == result_out[15])
      else $error("subtract negative flag does not match result");
endmodule // ssta_alu_monitor
bind ssta_alu ssta_alu_monitor i_ssta_alu_monitor (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .req_valid_in(req_valid_in), .req_in(req_in), .flags_in(flags_in), .busy_out(busy_out),
   .prog_req_valid_out(prog_req_valid_out), .prog_req_out(prog_req_out),
   .result_valid_out(result_valid_out), .result_write_out(result_write_out),
   .result_out(result_out), .flags_write_out(flags_write_out), .flags_out(flags_out));
`default_nettype wire

// [tb/tb_ssta_alu.sv]
// self-checking bench for the datapath
`timescale 1ns/1ns
`default_nettype none
module tb_ssta_alu import ssta_pkg::*;;
   typedef struct packed {logic w; logic fw; logic [15:0] r; ssta_flags_t f;} ssta_exp_t;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic req_valid_in = 1'b0;
   ssta_req_t req_in = '0;
   ssta_flags_t flags_in = '0;
   logic [23:0] prog_rdata_in = 24'h000000;
   logic busy_out, prog_req_valid_out, result_valid_out, result_write_out, flags_write_out;
   ssta_prog_req_t prog_req_out;
   logic [15:0] result_out;
   ssta_flags_t flags_out;
   ssta_exp_t q[$];
   ssta_exp_t e;
   int fail_count = 0;
   int n_checks = 0;
   int seed = 29499;
   ssta_alu i_ssta_alu (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .flags_in(flags_in), .busy_out(busy_out),
      .prog_req_valid_out(prog_req_valid_out), .prog_req_out(prog_req_out),
      .prog_rdata_in(prog_rdata_in), .result_valid_out(result_valid_out),
      .result_write_out(result_write_out), .result_out(result_out),
      .flags_write_out(flags_write_out), .flags_out(flags_out));
   initial forever #10 clk_in = ~clk_in;
   task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // c and dc read as not-borrow
   function automatic ssta_exp_t sub(input logic [15:0] a, b, input ssta_flags_t fi);
      logic [16:0] d;
      logic [4:0] h;
      d = {1'b0, a} - {1'b0, b} - {16'h0000, ~fi.c};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~fi.c};
      return {2'b11, d[15:0], ~h[4], d[15], (a[15] ^ b[15]) & (d[15] ^ a[15]), ~|d[15:0], ~d[16]};
   endfunction
   function automatic ssta_exp_t shl(input logic [15:0] r, input ssta_flags_t fi);
      return {2'b11, r, fi.dc, r[15], fi.ov, ~|r, fi.c};
   endfunction
   // ----------------------------------------
   // result watcher
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (!sys_rst_in && result_valid_out) begin
         if (q.size() == 0) chk(21'h1, 21'h0);
         else begin
            e = q.pop_front();
            chk({result_write_out, flags_write_out}, {e.w, e.fw});
            if (e.w) chk(result_out, e.r);
            if (e.fw) chk(flags_out, e.f);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      fail_count++;
      finish_test();
   end
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin
      logic [3:0] op;
      logic [15:0] a, b, l;
      logic [23:0] w;
      ssta_flags_t fi;
      ssta_exp_t x;
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      for (int i = 0; i < 600; i++) begin
         @(posedge clk_in);
         op = 4'($unsigned($random(seed)) % 12);
         a = 16'($random(seed));
         b = 16'($random(seed));
         l = 16'($random(seed));
         w = 24'($random(seed));
         fi = 5'($random(seed));
         req_valid_in <= 1'b1;
         req_in <= '{op: ssta_op_t'(op), opa: a, opb: b, lit: l, paddr: w};
         flags_in <= fi;
         case (ssta_op_t'(op))
            SSTA_OP_SHIFT_LEFT_REG: x = shl(a << b[3:0], fi);
            SSTA_OP_SHIFT_LEFT_LIT: x = shl(a << l[3:0], fi);
            SSTA_OP_SUBTRACT_WITH_BORROW_OP_MEM: x = sub(a, b, fi);
            SSTA_OP_SUBTRACT_WITH_BORROW_OP_LIT10: x = sub(a, l & 16'h03FF, fi);
            SSTA_OP_REVERSE_SUBTRACT_BORROW_OP_MEM: x = sub(b, a, fi);
            SSTA_OP_REVERSE_SUBTRACT_BORROW_OP_LIT5: x = sub(l & 16'h001F, a, fi);
            SSTA_OP_TBL_RD_HIGH: x = {2'b10, 8'h00, w[23:16], 5'h00};
            SSTA_OP_TBL_RD_LOW: x = {2'b10, w[15:0], 5'h00};
            SSTA_OP_ZERO_EXTEND: x = {2'b11, 8'h00, a[7:0], fi.dc, 1'b0, fi.ov, ~|a[7:0], 1'b1};
            default: x = '0;
         endcase
         if (op != 4'h0) q.push_back(x);
         if (op >= 4'h7 && op <= 4'hA) begin
            @(posedge clk_in);
            // request during busy must be dropped
            req_in.op <= SSTA_OP_SUBTRACT_WITH_BORROW_OP_MEM;
            prog_rdata_in <= w;
            @(posedge clk_in);
            req_valid_in <= 1'b0;
            prog_rdata_in <= ~w;
         end
      end
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      chk(q.size(), 21'h0);
      finish_test();
   end
endmodule // tb_ssta_alu
`default_nettype wire
